// ---- hdl/scne_core.sv ----
// instruction executer for negate, multiply write, stack, relative call and reset
// What this block does
// RL1 - multiply runs unsigned working times file, puts the 16-bit product high and low, no flag change.
// RL2 - negate replaces the file byte by its two's complement and sets negative, overflow, carry, digit carry and zero.
// RL3 - with bank bit 0 the access bank is used, with bank bit 1 the bank select register forms the address.
// RL4 - pop discards the top stack entry in the third phase and changes nothing else.
// RL5 - after a pop the entry pushed before the discarded one is the new top.
// RL6 - push writes program counter plus two onto the stack in the second phase, no flags touched.
// RL7 - on a push the old top moves one level down and is kept.
// RL8 - relative call pushes program counter plus two, then loads that plus twice the offset into the counter.
// RL9 - the call offset is a signed word count from -1024 to 1023, doubled before the add.
// RL10 - relative call takes two instruction cycles, the second one doing nothing.
// RL11 - the reset opcode returns every register and flag except the debug file pointer and the file memory to its reset value, starting in the second phase.
// RL12 - the all-zero word and any word starting 1111 are one-cycle no operations.
// RL13 - data instructions decode in phase one, read in two, compute in three and write in four.
`timescale 1ns/1ps
`default_nettype none

module scne_core
  import scne_pkg::*;
#(
  parameter int STK_DEPTH = scne_pkg::STK_DEP,
  parameter int FMEM_AW   = scne_pkg::FA_W
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             exec_busy,
  output logic             instr_done
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [7:0]        wreg_r;
  logic [4:0]        status_r;
  logic [3:0]        bsr_r;
  logic [PC_W-1:0]   pc_r;
  logic [15:0]       prod_r;
  logic [FA_W-1:0]   faddr_r;
  logic [15:0]       ir_r;
  scne_op_t          op_r;
  scne_phase_t       ph_r;
  logic              busy_r;
  logic              second_r;
  logic [7:0]        neg_res_r;
  logic [4:0]        neg_fl_r;
  logic [15:0]       mul_res_r;
  logic              ap_wr_r;
  logic              ap_rd_r;
  logic              ap_hit_r;
  logic [7:0]        ap_off_r;
  logic [1:0]        rd_cnt_r;
  logic [31:0]       hrdata_r;
  logic [31:0]       rd_mux;
  logic              ap_take;
  logic              ap_map;
  logic              bus_wr;
  logic              soft_rst;
  logic              last_q4;
  logic [PC_W-1:0]   pc_plus2;
  logic [PC_W-1:0]   call_disp;
  logic [FA_W-1:0]   op_faddr;
  logic [8:0]        neg_sum;
  logic [4:0]        neg_lo;

  scne_stk_if #(.W(PC_W), .PW(STK_PW)) stk_if ();
  scne_fm_if  #(.AW(FMEM_AW))          fm_if ();

  if (FMEM_AW != FA_W || STK_DEPTH > (2**STK_PW) - 1 || STK_DEPTH < 2)
  begin : g_chk
    $error("scne_core: memory width or stack depth not supported");
  end

  // ------------------------------------------------------------
  // bus slave: address phase capture
  // ------------------------------------------------------------
  assign ap_take = hsel && htrans[1] && hready;
  assign ap_map  = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00)
                   && (haddr[7:0] <= OFF_FDATA);
  assign bus_wr  = ap_wr_r && ap_hit_r && !busy_r;   // writes land only while idle

  // hold the request for its data phase
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ap_wr_r  <= 1'b0;
      ap_rd_r  <= 1'b0;
      ap_hit_r <= 1'b0;
      ap_off_r <= 8'h00;
    end
    else if (hreadyout)
    begin
      ap_wr_r  <= ap_take && hwrite;
      ap_rd_r  <= ap_take && !hwrite;
      ap_hit_r <= ap_take && ap_map;
      ap_off_r <= haddr[7:0];
    end
  end

  // read data are taken after two wait states so that earlier writes show
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_cnt_r <= 2'h0;
      hrdata_r <= 32'h00000000;
    end
    else if (hreadyout && ap_take && !hwrite)
      rd_cnt_r <= RD_WAIT;
    else if (rd_cnt_r != 2'h0)
    begin
      rd_cnt_r <= rd_cnt_r - 2'h1;
      if (rd_cnt_r == 2'h1)
        hrdata_r <= ap_hit_r ? rd_mux : 32'h00000000;   // unmapped reads give zero
    end
  end

  // register read mux
  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (ap_off_r)
      OFF_INSTR:  rd_mux = {16'h0000, ir_r};
      OFF_WREG:   rd_mux = {24'h000000, wreg_r};
      OFF_STATUS: rd_mux = {27'h0000000, status_r};
      OFF_BSR:    rd_mux = {28'h0000000, bsr_r};
      OFF_PC:     rd_mux = {11'h000, pc_r};
      OFF_TOS:    rd_mux = {11'h000, stk_if.top};
      OFF_PROD:   rd_mux = {16'h0000, prod_r};
      OFF_STAT:
      begin
        rd_mux[ST_BUSY]                   = busy_r;
        rd_mux[ST_SECOND]                 = second_r;
        rd_mux[ST_DEPTH +: STK_PW]        = stk_if.depth;
      end
      OFF_FADDR:  rd_mux = {20'h00000, faddr_r};
      OFF_FDATA:  rd_mux = {24'h000000, fm_if.rdata};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  assign hreadyout = (rd_cnt_r == 2'h0);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // ------------------------------------------------------------
  // sequencer: four phases per instruction cycle
  // ------------------------------------------------------------
  assign last_q4  = busy_r && (ph_r == PH_Q4) && !(op_r == K_CALL && !second_r);
  assign soft_rst = busy_r && (ph_r == PH_Q2) && (op_r == K_RST);             // RL11

  // start on a write of the instruction word, step the phases while busy
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_r   <= 1'b0;
      second_r <= 1'b0;
      ph_r     <= PH_Q1;
      ir_r     <= OP_NOP;
      op_r     <= K_NOP;
    end
    else if (soft_rst)
    begin
      busy_r   <= 1'b0;                                            // RL11
      second_r <= 1'b0;
      ph_r     <= PH_Q1;
      ir_r     <= OP_NOP;
      op_r     <= K_NOP;
    end
    else if (!busy_r)
    begin
      if (bus_wr && ap_off_r == OFF_INSTR)
      begin
        ir_r   <= hwdata[15:0];
        busy_r <= 1'b1;
        ph_r   <= PH_Q1;
      end
    end
    else
    begin
      unique case (ph_r)
        PH_Q1:
        begin
          if (!second_r)
            op_r <= scne_decode(ir_r);                             // RL12 RL13
          ph_r <= PH_Q2;
        end
        PH_Q2: ph_r <= PH_Q3;
        PH_Q3: ph_r <= PH_Q4;
        PH_Q4:
        begin
          ph_r <= PH_Q1;
          if (op_r == K_CALL && !second_r)
            second_r <= 1'b1;                                      // RL10
          else
          begin
            busy_r   <= 1'b0;
            second_r <= 1'b0;
          end
        end
      endcase
    end
  end

  assign exec_busy  = busy_r;
  assign instr_done = last_q4 || soft_rst;

  // ------------------------------------------------------------
  // operand address and compute
  // ------------------------------------------------------------
  assign op_faddr  = scne_faddr(ir_r[8], ir_r[7:0], bsr_r);                    // RL3
  assign pc_plus2  = pc_r + PC_W'(2);
  assign call_disp = {{(PC_W - 12){ir_r[10]}}, ir_r[10:0], 1'b0};             // RL9
  assign neg_sum   = {1'b0, ~fm_if.rdata} + 9'h001;
  assign neg_lo    = {1'b0, ~fm_if.rdata[3:0]} + 5'h01;

  // the file byte read in phase two is processed in phase three
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      neg_res_r <= 8'h00;
      neg_fl_r  <= RST_STATUS;
      mul_res_r <= RST_PROD;
    end
    else if (busy_r && ph_r == PH_Q3)
    begin
      neg_res_r           <= neg_sum[7:0];                         // RL2
      neg_fl_r[FL_C]      <= neg_sum[8];
      neg_fl_r[FL_DC]     <= neg_lo[4];
      neg_fl_r[FL_Z]      <= (neg_sum[7:0] == 8'h00);
      neg_fl_r[FL_OV]     <= fm_if.rdata[7] && neg_sum[7];
      neg_fl_r[FL_N]      <= neg_sum[7];
      mul_res_r           <= {8'h00, wreg_r} * {8'h00, fm_if.rdata}; // RL1
    end
  end

  // ------------------------------------------------------------
  // file memory and stack
  // ------------------------------------------------------------
  assign fm_if.addr  = busy_r ? op_faddr : faddr_r;
  assign fm_if.we    = (busy_r && ph_r == PH_Q4 && op_r == K_NEG && !second_r)  // RL2 RL13
                       || (bus_wr && ap_off_r == OFF_FDATA);
  assign fm_if.wdata = busy_r ? neg_res_r : hwdata[7:0];

  assign stk_if.push  = busy_r && !second_r && ph_r == PH_Q2
                        && (op_r == K_PUSH || op_r == K_CALL);        // RL6 RL8
  assign stk_if.pop   = busy_r && ph_r == PH_Q3 && op_r == K_POP;     // RL4
  assign stk_if.clr   = soft_rst;                                     // RL11
  assign stk_if.wdata = pc_plus2;

  scne_stack #(.DEPTH(STK_DEPTH), .W(PC_W), .PW(STK_PW)) u_stack (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .s       (stk_if)
  );

  scne_fmem #(.AW(FMEM_AW)) u_fmem (
    .clk_sys (clk_sys),
    .m       (fm_if)
  );

  // ------------------------------------------------------------
  // architectural registers
  // ------------------------------------------------------------
  // program counter: plus two per instruction, call target on the first cycle
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pc_r <= RST_PC;
    else if (soft_rst)
      pc_r <= RST_PC;                                              // RL11
    else if (busy_r && ph_r == PH_Q4 && !second_r)
    begin
      if (op_r == K_CALL)
        pc_r <= pc_plus2 + call_disp;                              // RL8
      else
        pc_r <= pc_plus2;
    end
    else if (bus_wr && ap_off_r == OFF_PC)
      pc_r <= hwdata[PC_W-1:0];
  end

  // status flags: of the instructions only negate and the reset opcode change them; bus writes also load them
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      status_r <= RST_STATUS;
    else if (soft_rst)
      status_r <= RST_STATUS;                                      // RL11
    else if (busy_r && ph_r == PH_Q4 && op_r == K_NEG)
      status_r <= neg_fl_r;                                        // RL2
    else if (bus_wr && ap_off_r == OFF_STATUS)
      status_r <= hwdata[4:0];
  end

  // product pair written in phase four of a multiply
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      prod_r <= RST_PROD;
    else if (soft_rst)
      prod_r <= RST_PROD;                                          // RL11
    else if (busy_r && ph_r == PH_Q4 && op_r == K_MUL)
      prod_r <= mul_res_r;                                         // RL1
  end

  // working register and bank select, set by software
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wreg_r <= RST_WREG;
      bsr_r  <= RST_BSR;
    end
    else if (soft_rst)
    begin
      wreg_r <= RST_WREG;                                          // RL11
      bsr_r  <= RST_BSR;
    end
    else if (bus_wr && ap_off_r == OFF_WREG)
      wreg_r <= hwdata[7:0];
    else if (bus_wr && ap_off_r == OFF_BSR)
      bsr_r  <= hwdata[3:0];
  end

  // debug pointer into the file memory
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      faddr_r <= RST_FADDR;
    else if (bus_wr && ap_off_r == OFF_FADDR)
      faddr_r <= hwdata[FA_W-1:0];
  end

endmodule : scne_core

`default_nettype wire

// ---- hdl/scne_pkg.sv ----
// constants, types and helpers shared by the stack, call and negate executer
package scne_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int PC_W    = 21;       // program counter width
  localparam int FA_W    = 12;       // file address width, bank:offset
  localparam int STK_DEP = 31;       // return stack entries
  localparam int STK_PW  = 5;        // stack pointer width

  // ------------------------------------------------------------
  // register offsets on the bus (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_INSTR  = 8'h00;
  localparam logic [7:0] OFF_WREG   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BSR    = 8'h0c;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_TOS    = 8'h14;
  localparam logic [7:0] OFF_PROD   = 8'h18;
  localparam logic [7:0] OFF_STAT   = 8'h1c;
  localparam logic [7:0] OFF_FADDR  = 8'h20;
  localparam logic [7:0] OFF_FDATA  = 8'h24;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int FL_C  = 0;          // carry
  localparam int FL_DC = 1;          // digit carry
  localparam int FL_Z  = 2;          // zero
  localparam int FL_OV = 3;          // overflow
  localparam int FL_N  = 4;          // negative
  localparam int ST_BUSY   = 0;      // status word: executing
  localparam int ST_SECOND = 1;      // status word: second cycle of a call
  localparam int ST_DEPTH  = 8;      // status word: stack depth, low bit
  localparam logic [7:0]      RST_WREG   = 8'h00;
  localparam logic [4:0]      RST_STATUS = 5'h00;
  localparam logic [3:0]      RST_BSR    = 4'h0;
  localparam logic [PC_W-1:0] RST_PC     = 21'h000000;
  localparam logic [15:0]     RST_PROD   = 16'h0000;
  localparam logic [FA_W-1:0] RST_FADDR  = 12'h000;
  localparam logic [3:0]      ACC_HI_BANK = 4'hf;  // upper half of the access bank
  localparam logic [3:0]      ACC_LO_BANK = 4'h0;  // lower half of the access bank
  localparam logic [1:0]      RD_WAIT    = 2'h2;   // wait states on a bus read

  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [15:0] OP_NOP   = 16'h0000;
  localparam logic [15:0] OP_PUSH  = 16'h0005;
  localparam logic [15:0] OP_POP   = 16'h0006;
  localparam logic [15:0] OP_RESET = 16'h00ff;
  localparam logic [6:0]  PFX_MUL  = 7'h01;   // 0000 001a
  localparam logic [6:0]  PFX_NEG  = 7'h36;   // 0110 110a
  localparam logic [4:0]  PFX_CALL = 5'h1b;   // 1101 1nnn
  localparam logic [3:0]  PFX_NOP  = 4'hf;    // 1111 xxxx

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } scne_phase_t;

  typedef enum logic [6:0] {
    K_NOP  = 7'b0000001,
    K_MUL  = 7'b0000010,
    K_NEG  = 7'b0000100,
    K_PUSH = 7'b0001000,
    K_POP  = 7'b0010000,
    K_RST  = 7'b0100000,
    K_CALL = 7'b1000000
  } scne_op_t;

  // sort an instruction word into one of the executed kinds
  function automatic scne_op_t scne_decode(input logic [15:0] iw);
    scne_op_t k;
    k = K_NOP;
    if (iw == OP_PUSH) k = K_PUSH;
    else if (iw == OP_POP) k = K_POP;
    else if (iw == OP_RESET) k = K_RST;
    else if (iw[15:9] == PFX_MUL) k = K_MUL;
    else if (iw[15:9] == PFX_NEG) k = K_NEG;
    else if (iw[15:11] == PFX_CALL) k = K_CALL;
    return k;
  endfunction : scne_decode

  // file address from the bank bit, the offset and the bank select
  function automatic logic [FA_W-1:0] scne_faddr(input logic a, input logic [7:0] f,
                                                 input logic [3:0] bsel);
    logic [3:0] bank;
    bank = a ? bsel : (f[7] ? ACC_HI_BANK : ACC_LO_BANK);
    return {bank, f};
  endfunction : scne_faddr

endpackage : scne_pkg

// ---- hdl/scne_if.sv ----
// carriers between the executer and its stack and file memory
`timescale 1ns/1ps
`default_nettype none

// return stack port
interface scne_stk_if #(parameter int W = 21, parameter int PW = 5);
  logic          push;
  logic          pop;
  logic          clr;
  logic [W-1:0]  wdata;
  logic [W-1:0]  top;
  logic [PW-1:0] depth;
  modport core (output push, pop, clr, wdata, input top, depth);
  modport stk  (input push, pop, clr, wdata, output top, depth);
endinterface : scne_stk_if

// file register memory port
interface scne_fm_if #(parameter int AW = 12);
  logic [AW-1:0] addr;
  logic          we;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport core (output addr, we, wdata, input rdata);
  modport mem  (input addr, we, wdata, output rdata);
endinterface : scne_fm_if

`default_nettype wire

// ---- hdl/scne_stack.sv ----
// hardware return stack with a registered top entry
`timescale 1ns/1ps
`default_nettype none

module scne_stack #(
  parameter int DEPTH = 31,
  parameter int W     = 21,
  parameter int PW    = 5
) (
  input wire logic clk_sys,
  input wire logic nrst,
  scne_stk_if.stk  s
);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] sp_r;
  logic [W-1:0]  top_r;
  logic          full;
  logic          empty;

  if (DEPTH < 2 || DEPTH > (2**PW) - 1)
  begin : g_chk
    $error("scne_stack: depth does not fit the pointer");
  end

  assign full  = (sp_r == PW'(DEPTH));
  assign empty = (sp_r == '0);

  // pointer and top: a push drops the old top one level, a pop raises the one below
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sp_r  <= '0;
      top_r <= '0;
    end
    else if (s.clr)
    begin
      sp_r  <= '0;
      top_r <= '0;
    end
    else if (s.push && !full)
    begin
      sp_r  <= sp_r + PW'(1);
      top_r <= s.wdata;                                            // RL6
    end
    else if (s.pop && !empty)
    begin
      sp_r  <= sp_r - PW'(1);                                      // RL4
      top_r <= (sp_r >= PW'(2)) ? mem[sp_r - PW'(2)] : '0;         // RL5
    end
  end

  // entries below the top stay where they were written
  always_ff @(posedge clk_sys)
  begin
    if (s.push && !full && !s.clr)
      mem[sp_r] <= s.wdata;                                        // RL7
  end

  assign s.top   = top_r;
  assign s.depth = sp_r;

endmodule : scne_stack

`default_nettype wire

// ---- hdl/scne_fmem.sv ----
// file register memory, one port, registered read data
`timescale 1ns/1ps
`default_nettype none

module scne_fmem #(
  parameter int AW = 12
) (
  input wire logic clk_sys,
  scne_fm_if.mem   m
);

  logic [7:0] mem [2**AW];
  logic [7:0] rd_r;

  if (AW < 8 || AW > 16)
  begin : g_chk
    $error("scne_fmem: address width out of range");
  end

  // write and read; a read in a write cycle returns the old byte
  always_ff @(posedge clk_sys)
  begin
    if (m.we)
      mem[m.addr] <= m.wdata;
    rd_r <= mem[m.addr];
  end

  assign m.rdata = rd_r;

endmodule : scne_fmem

`default_nettype wire

// ---- bench/scne_core_checker.sv ----
// concurrent checks on the executer's bus handshake and instruction timing
`timescale 1ns/1ps
`default_nettype none

module scne_core_checker (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        exec_busy,
  input wire logic        instr_done
);
  // ----
  // helpers
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic go_rd;
  logic go_wr;
  logic iw_r;
  // transfers accepted on this edge
  assign go_rd = hsel && htrans[1] && hready && !hwrite;
  assign go_wr = hsel && htrans[1] && hready && hwrite;
  // data phase of an instruction write accepted while idle
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst) iw_r <= 1'b0;
    else iw_r <= go_wr && haddr == 32'h0 && !exec_busy;

  // ----
  // properties
  // ----
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (go_rd |=> !hreadyout [*2] ##1 hreadyout)
    else $error("read wait states wrong");
  a_write_nowait: assert property (go_wr |=> hreadyout)
    else $error("write data phase stalled");
  a_busy_start: assert property (iw_r |=> exec_busy)
    else $error("instruction did not start");
  a_one_cycle: assert property (iw_r && hwdata[15:11] != 5'h1b
    && hwdata[15:0] != 16'h00ff |=> !instr_done [*3] ##1 instr_done)
    else $error("single cycle instruction not done in its fourth phase");
  a_call_two: assert property (iw_r && hwdata[15:11] == 5'h1b
    |=> !instr_done [*7] ##1 instr_done)
    else $error("relative call not done after two cycles");
  a_reset_q2: assert property (iw_r && hwdata[15:0] == 16'h00ff |=> ##1 instr_done)
    else $error("reset opcode not acting in second phase");
  a_done_drop: assert property (instr_done |=> !exec_busy && !instr_done)
    else $error("busy or done held after completion");
  a_busy_fell: assert property ($fell(exec_busy) |-> $past(instr_done))
    else $error("busy dropped without completion");
  c_call: cover property (iw_r && hwdata[15:11] == 5'h1b);
  c_reset: cover property (iw_r && hwdata[15:0] == 16'h00ff);
  c_read: cover property (go_rd ##3 hreadyout);
endmodule : scne_core_checker

bind scne_core scne_core_checker u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .exec_busy(exec_busy),
  .instr_done(instr_done)
);

`default_nettype wire

// ---- bench/scne_core_tb.sv ----
// self-checking bench: bus master tasks, reference model and scenarios
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module scne_core_tb;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic        exec_busy;
  logic        instr_done;
  int          mismatches = 0;
  int          checked = 0;
  int          w, st, bs, pc, prod, v, fa, f;
  int          stk[$];
  int          fm[int];
  int          vals[5] = '{0, 128, 58, 1, 255};

  // ----
  // clock and design
  // ----
  always #50 clk_sys = ~clk_sys;

  scne_core dut (
    .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .exec_busy(exec_busy),
    .instr_done(instr_done)
  );

  // ----
  // tasks
  // ----
  task automatic close_out();
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  // wait until ready is sampled high at a rising edge, bounded
  task automatic wt();
    int n;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) mismatches++;   // bounded wait ran out
    @(posedge clk_sys);
  endtask : wt

  // one single word transfer; read data lands in q
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : $urandom;
    wt();
    q = hrdata;
  endtask : bus

  // file address that the model expects
  function automatic int fad(input logic a, input int fo);
    return a ? bs * 256 + fo : (fo > 127 ? 3840 + fo : fo);
  endfunction : fad

  // compare every visible register except instruction, file address and file data with the model
  task automatic chk();
    bus(8'h04, 1'b0, 32'h0);
    `CHK(q, w)
    bus(8'h08, 1'b0, 32'h0);
    `CHK(q, st)
    bus(8'h0c, 1'b0, 32'h0);
    `CHK(q, bs)
    bus(8'h10, 1'b0, 32'h0);
    `CHK(q, pc)
    bus(8'h14, 1'b0, 32'h0);
    `CHK(q, stk.size() ? stk[$] : 0)
    bus(8'h18, 1'b0, 32'h0);
    `CHK(q, prod)
    bus(8'h1c, 1'b0, 32'h0);
    `CHK(q, stk.size() * 256)
  endtask : chk

  // issue one instruction, optionally try a write while busy, then model and check
  task automatic run(input logic [15:0] iw, input bit hit);
    int n;
    bus(8'h00, 1'b1, {16'h0, iw});
    if (hit) bus(8'h04, 1'b1, $urandom);
    n = 0;
    do
    begin
      bus(8'h1c, 1'b0, 32'h0);
      n++;
    end
    while (q[0] !== 1'b0 && n < 20);
    if (q[0] !== 1'b0) mismatches++;        // instruction never finished
    f = iw[7:0];
    fa = fad(iw[8], f);
    v = fm.exists(fa) ? fm[fa] : 0;
    if (iw == 16'h00ff)
    begin
      w = 0;
      st = 0;
      bs = 0;
      pc = 0;
      prod = 0;
      stk.delete();
    end
    else
    begin
      if (iw == 16'h0005 && stk.size() < 31) stk.push_back((pc + 2) & 'h1fffff);
      if (iw == 16'h0006 && stk.size() > 0) stk.pop_back();
      if (iw[15:9] == 7'h01) prod = w * v;
      if (iw[15:9] == 7'h36)
      begin
        fm[fa] = (256 - v) & 255;
        st = (fm[fa] > 127 ? 16 : 0) + (v == 128 ? 8 : 0) + (fm[fa] == 0 ? 4 : 0)
             + (v % 16 == 0 ? 2 : 0) + (v == 0 ? 1 : 0);
      end
      if (iw[15:11] == 5'h1b)
      begin
        stk.push_back((pc + 2) & 'h1fffff);
        pc = pc + 2 * (int'(iw[10:0]) - (iw[10] ? 2048 : 0));
      end
      pc = (pc + 2) & 'h1fffff;
    end
    chk();
  endtask : run

  // ----
  // scenarios
  // ----
  initial
  begin
    void'($urandom(32'h534e));
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk();
    bus(8'h28, 1'b1, 32'h5a);
    bus(8'h28, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    // negate then multiply on boundary and random operands, both bank modes
    for (int i = 0; i < 12; i++)
    begin
      v = i < 5 ? vals[i] : $urandom % 256;
      w = $urandom % 256;
      bs = $urandom % 16;
      f = $urandom % 256;
      fa = fad(i[0], f);
      fm[fa] = v;
      bus(8'h04, 1'b1, w);
      bus(8'h0c, 1'b1, bs);
      bus(8'h20, 1'b1, fa);
      bus(8'h24, 1'b1, v);
      run({7'h36, i[0], f[7:0]}, 1'b0);
      bus(8'h24, 1'b0, 32'h0);
      `CHK(q, fm[fa])
      run({7'h01, i[0], f[7:0]}, 1'b0);
    end
    // fill the return stack past full, then drain past empty
    pc = 'h124;
    bus(8'h10, 1'b1, pc);
    repeat (33) run(16'h0005, 1'b0);
    repeat (33) run(16'h0006, 1'b0);
    // relative calls at both offset limits and one random offset
    for (int i = 0; i < 3; i++)
    begin
      pc = ('h10000 + $urandom % 'h1000) * 2;
      bus(8'h10, 1'b1, pc);
      run(i == 0 ? 16'hdc00 : i == 1 ? 16'hdbff : {5'h1b, 11'($urandom)}, 1'b0);
    end
    run(16'h0000, 1'b1);
    run({4'hf, 12'($urandom)}, 1'b1);
    run(16'h00ff, 1'b0);
    close_out();
  end

  // watchdog against a hung handshake
  initial
  begin
    #3000000;
    mismatches++;
    close_out();
  end
endmodule : scne_core_tb

`default_nettype wire
